// *** hdl/lxl_lane_xbar_lmfc.sv ***
// lane crossbar, receive LMFC delay, buffer read point and latency measurement
// assumes lane data, LMFC and boundary pulses come from logic on pclk
//
// Decided for this implementation: the APB interface to the registers.
`include "lxl_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module lxl_lane_xbar_lmfc
    import lxl_pkg::*;
#(
    parameter int          LANE_W          = 40,
    parameter logic [3:0]  LINK0_LANE_MASK = 4'h3,
    parameter logic [3:0]  LINK1_LANE_MASK = 4'hC
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [13:0]        paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output var  logic [31:0]        prdata,
    output var  logic               pready,
    output var  logic               pslverr,
    input  wire logic               lmfc_internal,
    input  wire logic [3:0]         lane_lmfc_boundary,
    input  wire logic [LANE_W-1:0]  serial_input_0,
    input  wire logic [LANE_W-1:0]  serial_input_1,
    input  wire logic [LANE_W-1:0]  serial_input_2,
    input  wire logic [LANE_W-1:0]  serial_input_3,
    input  wire logic [LANE_W-1:0]  serial_input_4,
    input  wire logic [LANE_W-1:0]  serial_input_5,
    input  wire logic [LANE_W-1:0]  serial_input_6,
    input  wire logic [LANE_W-1:0]  serial_input_7,
    output var  logic [LANE_W-1:0]  logical_lane0,
    output var  logic [LANE_W-1:0]  logical_lane1,
    output var  logic [LANE_W-1:0]  logical_lane2,
    output var  logic [LANE_W-1:0]  logical_lane3,
    output var  logic               link0_rx_lmfc,
    output var  logic               link1_rx_lmfc,
    output var  logic               link0_buffer_read,
    output var  logic               link1_buffer_read
);

    // ---------------- apb slave ----------------
    logic                 pready_q;
    logic                 pslverr_q;
    logic [31:0]          prdata_q;
    logic                 dual_link_q;
    lxl_cycles_type       ofs_q   [2];
    lxl_cycles_type       rdpt_q  [2];
    lxl_cycles_type       lat_q   [2];
    lxl_lane_sel_type     sel_q   [4];

    wire                  acc_cycle = psel & penable & ~pready_q;
    wire                  wr_commit = psel & penable & pready_q & pwrite & ~pslverr_q;
    wire                  wr_lane0  = pstrb[0];
    wire                  word_ok   = (paddr[1:0] == 2'b00);
    wire lxl_index_type   idx       = paddr[13:2];

    wire hit_lat0  = word_ok & (idx == `LXL_IDX_LAT0);
    wire hit_lat1  = word_ok & (idx == `LXL_IDX_LAT1);
    wire hit_ofs0  = word_ok & (idx == `LXL_IDX_OFS0);
    wire hit_ofs1  = word_ok & (idx == `LXL_IDX_OFS1);
    wire hit_rdpt0 = word_ok & (idx == `LXL_IDX_RDPT0);
    wire hit_rdpt1 = word_ok & (idx == `LXL_IDX_RDPT1);
    wire hit_map01 = word_ok & (idx == `LXL_IDX_MAP01);
    wire hit_map23 = word_ok & (idx == `LXL_IDX_MAP23);
    wire hit_mode  = word_ok & (idx == `LXL_IDX_MODE);
    wire hit_any   = hit_lat0 | hit_lat1 | hit_ofs0 | hit_ofs1 | hit_rdpt0 | hit_rdpt1
                   | hit_map01 | hit_map23 | hit_mode;

    // read-only latency registers refuse writes with an error
    wire bad_wr    = pwrite & (hit_lat0 | hit_lat1);

    // reserved bits 31:6 come back as zero
    wire [5:0] rd_field =
          hit_lat0  ? lat_q[0]
        : hit_lat1  ? lat_q[1]
        : hit_ofs0  ? ofs_q[0]
        : hit_ofs1  ? ofs_q[1]
        : hit_rdpt0 ? rdpt_q[0]
        : hit_rdpt1 ? rdpt_q[1]
        : hit_map01 ? {sel_q[1], sel_q[0]}
        : hit_map23 ? {sel_q[3], sel_q[2]}
        : hit_mode  ? {5'h00, dual_link_q}
        : 6'h00;
    wire [31:0] rd_word = {26'h0000000, rd_field};

    // one wait state: answer on the second access-phase edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            pready_q  <= acc_cycle;
            pslverr_q <= acc_cycle & (~hit_any | bad_wr);
            if (acc_cycle & ~pwrite) begin
                prdata_q <= rd_word;
            end
        end
    end

    wire [5:0] wr_field = pwdata[5:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ofs_q[0]    <= `LXL_RST_OFS;
            ofs_q[1]    <= `LXL_RST_OFS;
            rdpt_q[0]   <= `LXL_RST_RDPT;
            rdpt_q[1]   <= `LXL_RST_RDPT;
            dual_link_q <= 1'b0;
        end else if (wr_commit & wr_lane0) begin
            if (hit_ofs0) ofs_q[0] <= wr_field;
            if (hit_ofs1) ofs_q[1] <= wr_field;
            if (hit_rdpt0) rdpt_q[0] <= wr_field;
            if (hit_rdpt1) rdpt_q[1] <= wr_field;
            if (hit_mode) dual_link_q <= pwdata[0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q[0] <= 3'(`LXL_RST_MAP01 >> `LXL_SEL_LO_LSB);
            sel_q[1] <= 3'(`LXL_RST_MAP01 >> `LXL_SEL_HI_LSB);
            sel_q[2] <= 3'(`LXL_RST_MAP23 >> `LXL_SEL_LO_LSB);
            sel_q[3] <= 3'(`LXL_RST_MAP23 >> `LXL_SEL_HI_LSB);
        end else if (wr_commit & wr_lane0) begin
            if (hit_map01) begin
                sel_q[0] <= wr_field[`LXL_SEL_LO_LSB +: `LXL_SEL_W];
                sel_q[1] <= wr_field[`LXL_SEL_HI_LSB +: `LXL_SEL_W];
            end
            if (hit_map23) begin
                sel_q[2] <= wr_field[`LXL_SEL_LO_LSB +: `LXL_SEL_W];
                sel_q[3] <= wr_field[`LXL_SEL_HI_LSB +: `LXL_SEL_W];
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ---------------- crossbar ----------------
    logic [LANE_W-1:0] phys [8];
    logic [LANE_W-1:0] lane_q [4];

    assign phys[0] = serial_input_0;
    assign phys[1] = serial_input_1;
    assign phys[2] = serial_input_2;
    assign phys[3] = serial_input_3;
    assign phys[4] = serial_input_4;
    assign phys[5] = serial_input_5;
    assign phys[6] = serial_input_6;
    assign phys[7] = serial_input_7;

    generate
        for (genvar g = 0; g < 4; g++) begin : g_lane
            // binary index straight into the physical array, sharing allowed
            wire [LANE_W-1:0] lane_d = phys[sel_q[g]];
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    lane_q[g] <= '0;
                end else begin
                    lane_q[g] <= lane_d;
                end
            end
        end
    endgenerate

    assign logical_lane0 = lane_q[0];
    assign logical_lane1 = lane_q[1];
    assign logical_lane2 = lane_q[2];
    assign logical_lane3 = lane_q[3];

    // ---------------- per-link LMFC delay, read point, latency ----------------
    logic [`LXL_HIST_DEPTH-1:0] lmfc_hist_q;
    logic                       rx_int    [2];
    logic                       rd_int    [2];
    logic                       rx_q      [2];
    logic                       rd_q      [2];
    logic                       armed_q   [2];
    logic [3:0]                 seen_q    [2];
    lxl_cycles_type             cnt_q     [2];
    wire                        link_on   [2];
    wire  [3:0]                 lane_mask [2];

    assign link_on[0]   = 1'b1;
    assign link_on[1]   = dual_link_q;
    assign lane_mask[0] = LINK0_LANE_MASK;
    assign lane_mask[1] = LINK1_LANE_MASK;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lmfc_hist_q <= '0;
        end else begin
            lmfc_hist_q <= {lmfc_hist_q[`LXL_HIST_DEPTH-2:0], lmfc_internal};
        end
    end

    generate
        for (genvar k = 0; k < 2; k++) begin : g_link
            logic [`LXL_HIST_DEPTH-1:0] rx_hist_q;
            wire [5:0] ofs_m1  = ofs_q[k] - 6'h01;
            wire [5:0] rdpt_m1 = rdpt_q[k] - 6'h01;
            // tap the delay line at the programmed cycle count
            wire tap_rx = (ofs_q[k] == 6'h00) ? lmfc_internal : lmfc_hist_q[ofs_m1];
            wire tap_rd = (rdpt_q[k] == 6'h00) ? rx_int[k] : rx_hist_q[rdpt_m1];
            assign rx_int[k] = link_on[k] & tap_rx;
            assign rd_int[k] = link_on[k] & tap_rd;

            wire [3:0] seen_now = lane_lmfc_boundary & lane_mask[k];
            wire [3:0] seen_d   = rx_int[k] ? seen_now : (seen_q[k] | seen_now);
            wire [5:0] cnt_cur  = rx_int[k] ? 6'h00 : cnt_q[k];
            wire       done     = (rx_int[k] | armed_q[k]) & (seen_d == lane_mask[k]);
            wire [5:0] cnt_inc  = (cnt_cur == `LXL_CNT_MAX) ? cnt_cur : cnt_cur + 6'h01;

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    rx_hist_q <= '0;
                    rx_q[k]   <= 1'b0;
                    rd_q[k]   <= 1'b0;
                end else begin
                    rx_hist_q <= {rx_hist_q[`LXL_HIST_DEPTH-2:0], rx_int[k]};
                    rx_q[k]   <= rx_int[k];
                    rd_q[k]   <= rd_int[k];
                end
            end

            // count from rx LMFC until every lane of the link has shown its boundary
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    armed_q[k] <= 1'b0;
                    seen_q[k]  <= 4'h0;
                    cnt_q[k]   <= 6'h00;
                    lat_q[k]   <= 6'h00;
                end else if (!link_on[k]) begin
                    armed_q[k] <= 1'b0;
                    seen_q[k]  <= 4'h0;
                    cnt_q[k]   <= 6'h00;
                end else begin
                    seen_q[k]  <= seen_d;
                    cnt_q[k]   <= cnt_inc;
                    armed_q[k] <= (rx_int[k] | armed_q[k]) & ~done;
                    if (done) begin
                        lat_q[k] <= cnt_cur;
                    end
                end
            end
        end
    endgenerate

    assign link0_rx_lmfc     = rx_q[0];
    assign link1_rx_lmfc     = rx_q[1];
    assign link0_buffer_read = rd_q[0];
    assign link1_buffer_read = rd_q[1];

    // ---------------- checks ----------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_rx0_zero_delay: assert property (
        (ofs_q[0] == 6'h00 && lmfc_internal) |=> link0_rx_lmfc)
        else $error("link 0 rx LMFC missing at zero delay");

    chk_rx1_one_delay: assert property (
        (dual_link_q && ofs_q[1] == 6'h01 && $stable(ofs_q[1]) && lmfc_internal)
        |=> ##1 link1_rx_lmfc)
        else $error("link 1 rx LMFC not one cycle late");

    chk_link1_idle_single: assert property (
        (!dual_link_q)[*2] |-> !link1_rx_lmfc && !link1_buffer_read)
        else $error("link 1 active in single-link mode");

    chk_read0_point: assert property (
        (rdpt_q[0] == 6'h00 && rx_int[0]) |=> link0_buffer_read && link0_rx_lmfc)
        else $error("link 0 read point not with rx LMFC");

    chk_read1_point: assert property (
        (dual_link_q && rdpt_q[1] == 6'h02 && $stable(rdpt_q[1]) && rx_int[1])
        |=> ##2 link1_buffer_read)
        else $error("link 1 read point wrong");

    chk_lane0_route: assert property (
        $past(presetn) |-> logical_lane0 == $past(phys[sel_q[0]]))
        else $error("logical lane 0 misrouted");

    chk_lane1_route: assert property (
        $past(presetn) |-> logical_lane1 == $past(phys[sel_q[1]]))
        else $error("logical lane 1 misrouted");

    chk_lane2_route: assert property (
        $past(presetn) |-> logical_lane2 == $past(phys[sel_q[2]]))
        else $error("logical lane 2 misrouted");

    chk_map01_write: assert property (
        (wr_commit && wr_lane0 && hit_map01) |=> sel_q[0] == $past(pwdata[2:0]))
        else $error("lane 0 source not written");

    chk_map23_write: assert property (
        (wr_commit && wr_lane0 && hit_map23) |=> sel_q[3] == $past(pwdata[5:3]))
        else $error("lane 3 source not written");

    chk_lat_wr_refused: assert property (
        (acc_cycle && pwrite && hit_lat0) |=> pready && pslverr)
        else $error("latency write not refused");

    chk_ofs0_write: assert property (
        (wr_commit && wr_lane0 && hit_ofs0) |=> ofs_q[0] == $past(pwdata[5:0]))
        else $error("link 0 offset not written");

    chk_rdpt1_write: assert property (
        (wr_commit && wr_lane0 && hit_rdpt1) |=> rdpt_q[1] == $past(pwdata[5:0]))
        else $error("link 1 read point not written");

    chk_lat1_frozen: assert property (
        !dual_link_q |=> $stable(lat_q[1]))
        else $error("link 1 latency moved in single-link mode");

    chk_lane3_route: assert property (
        (sel_q[3] == 3'h7) |=> logical_lane3 == $past(serial_input_7))
        else $error("logical lane 3 code 7 misrouted");

    chk_reserved_zero: assert property (
        (pready && !pslverr && !pwrite) |-> prdata[31:6] == 26'h0000000)
        else $error("reserved read bits not zero");

    chk_lat0_capture: assert property (
        (rx_int[0] && lane_lmfc_boundary == 4'hF) |=> lat_q[0] == 6'h00)
        else $error("link 0 latency not zero on same-cycle boundary");

    chk_lat1_capture: assert property (
        (g_link[1].done && !rx_int[1] && dual_link_q) |=> lat_q[1] == $past(cnt_q[1]))
        else $error("link 1 latency not captured");

    cov_shared_source: cover property (sel_q[0] == sel_q[1]);
    cov_dual_measure:  cover property (dual_link_q && g_link[1].done);
    cov_apb_write:     cover property (wr_commit && hit_map23);
    cov_read_zero:     cover property (rdpt_q[0] == 6'h00 && rx_int[0]);
    cov_lat_zero:      cover property (rx_int[0] && g_link[0].done);

endmodule
`default_nettype wire

// *** hdl/lxl_consts.svh ***
// register offsets, field positions, reset values and counts of the lane crossbar and LMFC block
// assumes APB with 32-bit data; each register index sits at byte address four times the index
`ifndef LXL_CONSTS_SVH
`define LXL_CONSTS_SVH

`define LXL_IDX_LAT0      12'h302
`define LXL_IDX_LAT1      12'h303
`define LXL_IDX_OFS0      12'h304
`define LXL_IDX_OFS1      12'h305
`define LXL_IDX_RDPT0     12'h306
`define LXL_IDX_RDPT1     12'h307
`define LXL_IDX_MAP01     12'h308
`define LXL_IDX_MAP23     12'h309
`define LXL_IDX_MODE      12'h30F

`define LXL_FIELD_W       6
`define LXL_SEL_LO_LSB    0
`define LXL_SEL_HI_LSB    3
`define LXL_SEL_W         3

`define LXL_RST_OFS       6'h00
`define LXL_RST_RDPT      6'h3F
`define LXL_RST_MAP01     6'h08
`define LXL_RST_MAP23     6'h1A
`define LXL_RDPT_MAX      6'h0C
`define LXL_CNT_MAX       6'h3F
`define LXL_HIST_DEPTH    63

`endif

// *** hdl/lxl_pkg.sv ***
// types shared by the lane crossbar and LMFC block
// assumes nothing beyond a SystemVerilog compiler
package lxl_pkg;
    typedef logic [2:0]  lxl_lane_sel_type;
    typedef logic [5:0]  lxl_cycles_type;
    typedef logic [11:0] lxl_index_type;
endpackage

// *** dv/lxl_tx_model.sv ***
// far-side transmitter model: eight lanes of changing data and lane boundary pulses
// assumes the bench calls pulse right after a rising edge of pclk
`timescale 1ns/1ps
`default_nettype none
module lxl_tx_model #(
    parameter int LANE_W = 40
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    output var  logic [36:0]       cnt,
    output var  logic [3:0]        boundary,
    output var  logic [LANE_W-1:0] lane [8]
);
    initial boundary = 4'h0;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 37'h0;
        end else begin
            cnt <= cnt + 37'h1;
        end
    end
    // lane tag in the top bits, cycle count below: new word every cycle
    for (genvar k = 0; k < 8; k++) begin : g_lane
        assign lane[k] = {3'(k), cnt};
    end
    task automatic pulse_now(input logic [3:0] m);
        boundary <= m;
        @(posedge pclk);
        boundary <= 4'h0;
    endtask
    task automatic pulse(input logic [3:0] m);
        @(posedge pclk);
        boundary <= m;
        @(posedge pclk);
        boundary <= 4'h0;
    endtask
endmodule
`default_nettype wire

// *** dv/lane_xbar_lmfc_latency_test.sv ***
// self-checking bench of the lane crossbar and LMFC block
// assumes the design files and lxl_consts.svh are compiled first
`include "lxl_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module lane_xbar_lmfc_latency_test;
    import lxl_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [13:0] paddr = 14'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        lmfc_internal = 1'b0;
    logic [3:0]  bnd;
    logic [36:0] cnt;
    logic [39:0] lane [8];
    logic [39:0] logical_lane0, logical_lane1, logical_lane2, logical_lane3;
    logic        link0_rx_lmfc, link1_rx_lmfc, link0_buffer_read, link1_buffer_read;
    int          n_mismatch = 0;
    int          n_tests = 0;
    always #20 pclk = ~pclk;
    lxl_tx_model i_lxl_tx_model (.pclk, .presetn, .cnt, .boundary(bnd), .lane);
    lxl_lane_xbar_lmfc i_lxl_lane_xbar_lmfc (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
        .prdata, .pready, .pslverr, .lmfc_internal, .lane_lmfc_boundary(bnd),
        .serial_input_0(lane[0]), .serial_input_1(lane[1]), .serial_input_2(lane[2]),
        .serial_input_3(lane[3]), .serial_input_4(lane[4]), .serial_input_5(lane[5]),
        .serial_input_6(lane[6]), .serial_input_7(lane[7]),
        .logical_lane0, .logical_lane1, .logical_lane2, .logical_lane3,
        .link0_rx_lmfc, .link1_rx_lmfc, .link0_buffer_read, .link1_buffer_read);
    task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic apb(input logic wr, input lxl_index_type idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) check("pready", 40'h0, 40'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input lxl_index_type idx, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, idx, d, rd, err);
    endtask
    task automatic rdchk(input string what, input lxl_index_type idx, input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, idx, 32'h0, rd, err);
        check(what, 40'(rd), 40'(exp));
    endtask
    task automatic t_reset;
        rdchk("lat0", `LXL_IDX_LAT0, 32'h0);
        rdchk("lat1", `LXL_IDX_LAT1, 32'h0);
        rdchk("ofs0", `LXL_IDX_OFS0, 32'h0);
        rdchk("ofs1", `LXL_IDX_OFS1, 32'h0);
        rdchk("rdpt0", `LXL_IDX_RDPT0, 32'h3F);
        rdchk("rdpt1", `LXL_IDX_RDPT1, 32'h3F);
        rdchk("map01", `LXL_IDX_MAP01, 32'h08);
        rdchk("map23", `LXL_IDX_MAP23, 32'h1A);
        $display("test reset values done");
    endtask
    task automatic t_regs;
        logic [31:0] rd;
        logic        err;
        wr(`LXL_IDX_OFS0, 32'hFF);
        rdchk("ofs0 reserved", `LXL_IDX_OFS0, 32'h3F);
        wr(`LXL_IDX_OFS1, 32'hD5);
        rdchk("ofs1", `LXL_IDX_OFS1, 32'h15);
        apb(1'b1, `LXL_IDX_LAT0, 32'h2A, rd, err);
        check("lat0 write err", 40'(err), 40'h1);
        rdchk("lat0 kept", `LXL_IDX_LAT0, 32'h0);
        apb(1'b0, 12'h300, 32'h0, rd, err);
        check("unmapped err", 40'(err), 40'h1);
        $display("test register access done");
    endtask
    task automatic t_xbar;
        for (int c = 0; c < 8; c++) begin
            wr(`LXL_IDX_MAP01, 32'({3'(7 - c), 3'(c)}));
            wr(`LXL_IDX_MAP23, 32'({3'(c), 3'h2}));
            @(posedge pclk);
            @(negedge pclk);
            check("lane0", logical_lane0, {3'(c), cnt - 37'h1});
            check("lane1", logical_lane1, {3'(7 - c), cnt - 37'h1});
            check("lane3", logical_lane3, {3'(c), cnt - 37'h1});
            check("lane2", logical_lane2, {3'h2, cnt - 37'h1});
        end
        wr(`LXL_IDX_MAP01, 32'h2D);
        @(posedge pclk);
        @(negedge pclk);
        check("shared lane0", logical_lane0, {3'h5, cnt - 37'h1});
        check("shared lane1", logical_lane1, {3'h5, cnt - 37'h1});
        $display("test crossbar done");
    endtask
    task automatic fire(output int t0, output int t1, output int r0, output int r1);
        t0 = 0;
        t1 = 0;
        r0 = 0;
        r1 = 0;
        @(posedge pclk);
        lmfc_internal <= 1'b1;
        for (int i = 1; i < 100; i++) begin
            @(posedge pclk);
            lmfc_internal <= 1'b0;
            @(negedge pclk);
            if (link0_rx_lmfc === 1'b1 && t0 == 0) t0 = i;
            if (link1_rx_lmfc === 1'b1 && t1 == 0) t1 = i;
            if (link0_buffer_read === 1'b1 && r0 == 0) r0 = i;
            if (link1_buffer_read === 1'b1 && r1 == 0) r1 = i;
        end
    endtask
    task automatic t_lmfc;
        int t0, t1, r0, r1;
        wr(`LXL_IDX_OFS0, 32'h2);
        wr(`LXL_IDX_RDPT0, 32'h1);
        wr(`LXL_IDX_OFS1, 32'h5);
        wr(`LXL_IDX_RDPT1, 32'hC);
        fire(t0, t1, r0, r1);
        check("rx0 delay", 40'(t0), 40'h3);
        check("read0 point", 40'(r0), 40'h4);
        check("rx1 single", 40'(t1 + r1), 40'h0);
        wr(`LXL_IDX_MODE, 32'h1);
        wr(`LXL_IDX_OFS0, 32'h3F);
        wr(`LXL_IDX_RDPT0, 32'hC);
        fire(t0, t1, r0, r1);
        check("rx1 delay", 40'(t1), 40'h6);
        check("read1 point", 40'(r1), 40'h12);
        check("rx0 max", 40'(t0), 40'h40);
        check("read0 max", 40'(r0), 40'h4C);
        wr(`LXL_IDX_OFS0, 32'h0);
        wr(`LXL_IDX_RDPT0, 32'h0);
        wr(`LXL_IDX_OFS1, 32'h1);
        wr(`LXL_IDX_RDPT1, 32'h2);
        fire(t0, t1, r0, r1);
        check("rx0 zero", 40'(t0), 40'h1);
        check("read0 zero", 40'(r0), 40'h1);
        check("rx1 one", 40'(t1), 40'h2);
        check("read1 two", 40'(r1), 40'h4);
        $display("test frame clock delays done");
    endtask
    task automatic lat_run(input lxl_index_type idx, input logic [3:0] a, input logic [3:0] b,
                           input int k, output logic [31:0] v);
        logic err;
        @(posedge pclk);
        lmfc_internal <= 1'b1;
        @(posedge pclk);
        lmfc_internal <= 1'b0;
        repeat (k) @(posedge pclk);
        i_lxl_tx_model.pulse(a);
        i_lxl_tx_model.pulse(b);
        repeat (4) @(posedge pclk);
        apb(1'b0, idx, 32'h0, v, err);
    endtask
    task automatic t_latency;
        logic [31:0] v0, v1;
        wr(`LXL_IDX_OFS0, 32'h0);
        wr(`LXL_IDX_OFS1, 32'h0);
        wr(`LXL_IDX_MODE, 32'h0);
        lat_run(`LXL_IDX_LAT1, 4'h4, 4'h8, 3, v0);
        check("lat1 frozen", 40'(v0), 40'h0);
        lat_run(`LXL_IDX_LAT0, 4'h1, 4'h2, 2, v0);
        lat_run(`LXL_IDX_LAT0, 4'h2, 4'h1, 6, v1);
        check("lat0 step", 40'(v1 - v0), 40'h4);
        check("lat0 high bits", 40'(v1[31:6]), 40'h0);
        wr(`LXL_IDX_MODE, 32'h1);
        lat_run(`LXL_IDX_LAT1, 4'h4, 4'h8, 1, v0);
        lat_run(`LXL_IDX_LAT1, 4'h8, 4'h4, 8, v1);
        check("lat1 step", 40'(v1 - v0), 40'h7);
        @(posedge pclk);
        lmfc_internal <= 1'b1;
        i_lxl_tx_model.pulse_now(4'hF);
        lmfc_internal <= 1'b0;
        rdchk("lat0 zero", `LXL_IDX_LAT0, 32'h0);
        rdchk("lat1 zero", `LXL_IDX_LAT1, 32'h0);
        $display("test measured latency done");
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        n_mismatch++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_regs();
        t_xbar();
        t_lmfc();
        t_latency();
        end_of_test();
    end
endmodule
`default_nettype wire
